// file: hdl/dacsi_pkg.sv
// Shared constants for the DAC serial input and update control block
`default_nettype none
package dacsi_pkg;
   // Frame layout
   localparam int          FRAME_BITS = 24;
   localparam int          RW_BIT     = 23;
   localparam int          ADDR_HI    = 22;
   localparam int          ADDR_LO    = 20;
   localparam int          DATA_HI    = 19;
   localparam int          DATA_W     = 20;
   localparam int          CODE_HI    = 19;
   localparam int          CODE_LO    = 2;
   localparam int          CODE_W     = 18;
   // Falling-edge counter: width, full frame and saturation value
   localparam int          CNT_W      = 5;
   localparam logic [4:0]  CNT_FRAME  = 5'h18;
   localparam logic [4:0]  CNT_SAT    = 5'h19;
   localparam logic [4:0]  CNT_LAST   = 5'h17;
   // Register addresses
   localparam logic [2:0]  ADDR_NOP   = 3'h0;
   localparam logic [2:0]  ADDR_DAC   = 3'h1;
   localparam logic [2:0]  ADDR_CTRL  = 3'h2;
   localparam logic [2:0]  ADDR_CLRC  = 3'h3;
   localparam logic [2:0]  ADDR_SWCTL = 3'h4;
   // Control register fields and reset value
   localparam int          CTRL_AMPBYP = 1;
   localparam int          CTRL_CLAMP  = 2;
   localparam int          CTRL_TRI    = 3;
   localparam int          CTRL_CODING = 4;
   localparam int          CTRL_RBDIS  = 5;
   localparam logic [19:0] CTRL_RST    = 20'h0_000E;
   localparam logic [19:0] CTRL_WMASK  = 20'h0_003E;
   // Clearcode, DAC code and readback word reset values
   localparam logic [17:0] CLRC_RST    = 18'h0_0000;
   localparam logic [17:0] CODE_RST    = 18'h0_0000;
   localparam logic [23:0] RB_IDLE     = 24'h00_0000;
   // Software control register action bits
   localparam int          SW_LOAD  = 0;
   localparam int          SW_CLEAR = 1;
   localparam int          SW_RESET = 2;
   // Synchroniser depth
   localparam int          SYNC_STAGES = 2;
endpackage
`default_nettype wire

// file: hdl/dacsi_sync.sv
// Two-stage level synchroniser into the system clock domain
`default_nettype none
module dacsi_sync import dacsi_pkg::*; #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // Level in and out
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] rst_val,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second; every bit resets to 1, and rst_val is not used
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_r[i]   <= 1'b1;
            sync_out[i] <= 1'b1;
         end else begin
            meta_r[i]   <= async_in[i];
            sync_out[i] <= meta_r[i];
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/dacsi_link.sv
// Serial-clock side: frame shifter, edge counter and readback bit select
`default_nettype none
module dacsi_link import dacsi_pkg::*; (
   // Link clock and resets
   input  wire logic             sclk,
   input  wire logic             rst_n,
   input  wire logic             frame_sel_n,
   // Serial data
   input  wire logic             serial_input_line,
   input  wire logic [23:0]      rb_word,
   output logic                  rb_bit,
   // Frozen frame results for the system domain
   output logic [23:0]           shift_word,
   output logic [CNT_W-1:0]      edge_cnt
);
   logic first_r;

   // Marks the first edge of a frame; the frame select itself rearms it,
   // so nothing depends on clock edges outside a frame
   always_ff @(negedge sclk or negedge rst_n or posedge frame_sel_n) begin
      if (!rst_n) begin
         first_r <= 1'b1;
      end else if (frame_sel_n) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   // Falling-edge counter, saturating so overlong frames stay visible
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         edge_cnt <= '0;
      end else if (!frame_sel_n) begin
         if (first_r) begin
            edge_cnt <= 5'h01;
         end else if (edge_cnt != CNT_SAT) begin
            edge_cnt <= edge_cnt + 5'h01;
         end
      end
   end

   // MSB first, sampled on falling edges; frozen while select is high
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_word <= RB_IDLE;
      end else if (!frame_sel_n) begin
         shift_word <= {shift_word[22:0], serial_input_line};
      end
   end

   // Readback bit changes just after each falling edge, so it is stable
   // for the host at the next falling edge
   always_comb begin
      if (first_r) begin
         rb_bit = rb_word[RW_BIT];
      end else if (edge_cnt <= CNT_LAST) begin
         rb_bit = rb_word[CNT_LAST - edge_cnt];
      end else begin
         rb_bit = 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: hdl/dacsi_top.sv
// DAC serial write and readback front end with output update control
// Functional notes
// - 24-bit frames shift in MSB first
// - Bit 23 R/W, 22..20 address, 19..0 data
// - Address zero is a no-operation
// - Writes reach DAC, control, clearcode, software control
// - Reads select DAC, control, clearcode
// - Early select rise discards the frame
// - Over 24 edges discards the frame
// - Valid frame commits on select rising edge
// - Next frame shifts the read data out
// - Readback line released while select high
// - Readbacks pipeline across consecutive frames
// - Readback needs driver enabled, enabled at reset
// - Load low: output updates at select rise
// - Load high: output updates on load fall
// - Reset low holds device, ignores frames
// - Reset release or software reset restores defaults
// - Clear low loads clearcode, blocks updates
// - Software clear bit acts like clear pin
// - DAC code is frame bits 19..2
// - Clearcode is an 18-bit written register
// - Clearcode resets to zero
// - Coding select resets to twos complement
`default_nettype none
module dacsi_top import dacsi_pkg::*; (
   // System clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // Serial link
   input  wire logic               sclk,
   input  wire logic               frame_sel_n,
   input  wire logic               serial_input_line,
   output logic                    serial_readback_line_o,
   output logic                    serial_readback_line_oe,
   // Hardware control pins
   input  wire logic               output_load_n,
   input  wire logic               clear_to_code_n,
   // Converter side
   output logic [CODE_W-1:0]       dac_level,
   output logic                    coding_select,
   output logic                    dac_tristate,
   output logic                    output_clamp,
   output logic                    amp_bypass
);
   logic [23:0]          shift_word;
   logic [CNT_W-1:0]     edge_cnt;
   logic                 rb_bit;
   logic [2:0]           pins_s;
   logic                 sel_s;
   logic                 load_s;
   logic                 clr_s;
   logic                 sel_d_r;
   logic                 frame_end;
   logic                 frame_ok;
   logic                 wr_en;
   logic [2:0]           addr;
   logic [DATA_HI:0]     data;
   logic                 clr_act;
   logic                 upd_ok;
   logic [CODE_W-1:0]    dac_output_code_r;
   logic [CODE_W-1:0]    clearcode_r;
   logic [DATA_HI:0]     ctrl_r;
   logic [23:0]          rb_word_r;
   logic [23:0]          rb_word_nxt;
   logic                 soft_rst_r;
   logic                 sw_clr_r;
   logic                 sw_load_r;

   // Checks below share the system clock and the reset pin
   default clocking dacsi_cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Link-clock logic
   dacsi_link u_link (
      .sclk              (sclk),
      .rst_n             (rst_n),
      .frame_sel_n       (frame_sel_n),
      .serial_input_line (serial_input_line),
      .rb_word           (rb_word_r),
      .rb_bit            (rb_bit),
      .shift_word        (shift_word),
      .edge_cnt          (edge_cnt)
   );

   // Pins into the system domain
   dacsi_sync #(.WIDTH(3)) u_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in ({frame_sel_n, output_load_n, clear_to_code_n}),
      .rst_val  (3'h7),
      .sync_out (pins_s)
   );
   assign sel_s  = pins_s[2];
   assign load_s = pins_s[1];
   assign clr_s  = pins_s[0];

   // Select rising edge; the link side is frozen by then, so its
   // word and count are stable across the crossing
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_d_r <= 1'b1;
      end else begin
         sel_d_r <= sel_s;
      end
   end
   assign frame_end = sel_s & ~sel_d_r;
   assign frame_ok  = frame_end && (edge_cnt == CNT_FRAME);

   // Frame decode
   assign addr  = shift_word[ADDR_HI:ADDR_LO];
   assign data  = shift_word[DATA_HI:0];
   assign wr_en = frame_ok && !shift_word[RW_BIT] && (addr != ADDR_NOP);

   // Clear from pin or software bit; blocks every output update except a software reset
   assign clr_act = !clr_s || sw_clr_r;
   // Update allowed while select is high and load is low or pulsed
   assign upd_ok  = sel_s && (!load_s || sw_load_r);

   // Software control actions are single-cycle pulses
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_rst_r <= 1'b0;
         sw_clr_r   <= 1'b0;
         sw_load_r  <= 1'b0;
      end else if (wr_en && addr == ADDR_SWCTL && !soft_rst_r) begin
         soft_rst_r <= data[SW_RESET];
         sw_clr_r   <= data[SW_CLEAR];
         sw_load_r  <= data[SW_LOAD];
      end else begin
         soft_rst_r <= 1'b0;
         sw_clr_r   <= 1'b0;
         sw_load_r  <= 1'b0;
      end
   end

   // DAC register: clear wins over a write in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_output_code_r <= CODE_RST;
      end else if (soft_rst_r) begin
         dac_output_code_r <= CODE_RST;
      end else if (clr_act) begin
         dac_output_code_r <= clearcode_r;
      end else if (wr_en && addr == ADDR_DAC) begin
         dac_output_code_r <= data[CODE_HI:CODE_LO];
      end
   end

   // Clearcode register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clearcode_r <= CLRC_RST;
      end else if (soft_rst_r) begin
         clearcode_r <= CLRC_RST;
      end else if (wr_en && addr == ADDR_CLRC) begin
         clearcode_r <= data[CODE_HI:CODE_LO];
      end
   end

   // Control register; reserved bits are never stored and read as zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
      end else if (soft_rst_r) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_en && addr == ADDR_CTRL) begin
         ctrl_r <= data & CTRL_WMASK;
      end
   end

   // Output latch: follows the DAC register only when an update is allowed
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_level <= CODE_RST;
      end else if (soft_rst_r) begin
         dac_level <= CODE_RST;
      end else if (clr_act) begin
         dac_level <= clearcode_r;
      end else if (upd_ok) begin
         dac_level <= dac_output_code_r;
      end
   end

   // Readback word for the next frame; every frame end consumes the
   // previous one, which is what lets reads pipeline
   always_comb begin
      rb_word_nxt = RB_IDLE;
      if (frame_ok && shift_word[RW_BIT]) begin
         unique case (addr)
            ADDR_DAC:  rb_word_nxt = {1'b1, addr, dac_output_code_r, 2'b00};
            ADDR_CTRL: rb_word_nxt = {1'b1, addr, ctrl_r};
            ADDR_CLRC: rb_word_nxt = {1'b1, addr, clearcode_r, 2'b00};
            default:   rb_word_nxt = RB_IDLE;
         endcase
      end
   end

   // Only changes while the select is high, so the link reads it stable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rb_word_r <= RB_IDLE;
      end else if (soft_rst_r) begin
         rb_word_r <= RB_IDLE;
      end else if (frame_end) begin
         rb_word_r <= rb_word_nxt;
      end
   end

   // Readback driver: released whenever select is high or disabled
   assign serial_readback_line_oe = !frame_sel_n && !ctrl_r[CTRL_RBDIS];
   assign serial_readback_line_o  = rb_bit & serial_readback_line_oe;

   // Converter configuration
   assign coding_select = ctrl_r[CTRL_CODING];
   assign dac_tristate  = ctrl_r[CTRL_TRI] | ctrl_r[CTRL_CLAMP];
   assign output_clamp  = ctrl_r[CTRL_CLAMP];
   assign amp_bypass    = ctrl_r[CTRL_AMPBYP];

   // Checks
   AST_NOP_KEEPS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (frame_ok && addr == ADDR_NOP) |=> ($stable(ctrl_r) && $stable(clearcode_r)))
      else $error("no-operation frame changed a register");

   AST_DAC_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_en && addr == ADDR_DAC && !clr_act && !soft_rst_r)
      |=> dac_output_code_r == $past(shift_word[CODE_HI:CODE_LO]))
      else $error("DAC write did not store bits 19 to 2");

   AST_BAD_FRAME: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (frame_end && edge_cnt != CNT_FRAME && !soft_rst_r)
      |=> ($stable(ctrl_r) && $stable(clearcode_r) && rb_word_r == RB_IDLE))
      else $error("invalid frame was committed");

   AST_CTRL_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (frame_ok && shift_word[RW_BIT] && addr == ADDR_CTRL && !soft_rst_r)
      |=> rb_word_r == {4'h2 | 4'h8, $past(ctrl_r)})
      else $error("control readback word wrong");

   AST_SDO_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (frame_sel_n || ctrl_r[CTRL_RBDIS]) |-> !serial_readback_line_oe)
      else $error("readback line driven outside a frame");

   AST_CLEAR_LOADS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!clr_s && !soft_rst_r)[*2] |-> (dac_level == clearcode_r && dac_output_code_r == clearcode_r))
      else $error("clear did not hold the clearcode");

   AST_LOAD_UPDATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (sel_s && !load_s && clr_s && !sw_clr_r && !soft_rst_r) |=> dac_level == $past(dac_output_code_r))
      else $error("load low did not update the output");

   AST_LOAD_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (load_s && !sw_load_r && clr_s && !sw_clr_r && !soft_rst_r) |=> $stable(dac_level))
      else $error("output changed with load high");

   AST_SOFT_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      soft_rst_r |=> (ctrl_r == CTRL_RST && clearcode_r == CLRC_RST && dac_level == CODE_RST))
      else $error("software reset left a register off its default");

   // Register, readback and update checks on the default clock
   AST_CLRC_WRITE: assert property (
      (wr_en && addr == ADDR_CLRC && !soft_rst_r) |=> clearcode_r == $past(data[CODE_HI:CODE_LO]))
      else $error("clearcode write lost");

   AST_CTRL_WRITE: assert property (
      (wr_en && addr == ADDR_CTRL && !soft_rst_r) |=> ctrl_r == ($past(data) & CTRL_WMASK))
      else $error("control write lost");

   AST_CTRL_RSVD: assert property (
      (ctrl_r & ~CTRL_WMASK) == 20'h0_0000)
      else $error("reserved control bit set");

   AST_DAC_READ: assert property (
      (frame_ok && shift_word[RW_BIT] && addr == ADDR_DAC && !soft_rst_r)
      |=> rb_word_r == {4'h9, $past(dac_output_code_r), 2'b00})
      else $error("DAC readback word wrong");

   AST_CLRC_READ: assert property (
      (frame_ok && shift_word[RW_BIT] && addr == ADDR_CLRC && !soft_rst_r)
      |=> rb_word_r == {4'hB, $past(clearcode_r), 2'b00})
      else $error("clearcode readback word wrong");

   AST_RB_BAD_ADDR: assert property (
      (frame_ok && shift_word[RW_BIT] && addr > ADDR_CLRC && !soft_rst_r) |=> rb_word_r == RB_IDLE)
      else $error("unreadable address gave readback data");

   AST_NOP_RB: assert property (
      (frame_ok && addr == ADDR_NOP && !soft_rst_r) |=> rb_word_r == RB_IDLE)
      else $error("no-operation frame left readback data");

   AST_WRITE_NO_RB: assert property (
      (frame_ok && !shift_word[RW_BIT] && !soft_rst_r) |=> rb_word_r == RB_IDLE)
      else $error("write frame left readback data");

   AST_RB_STEADY: assert property (
      (!frame_end && !soft_rst_r) |=> $stable(rb_word_r))
      else $error("readback word moved between frames");

   AST_FRAME_END_ONCE: assert property (
      frame_end |=> !frame_end)
      else $error("frame end longer than one cycle");

   AST_REGS_AT_COMMIT: assert property (
      (!frame_ok && !soft_rst_r) |=> ($stable(ctrl_r) && $stable(clearcode_r)))
      else $error("register changed outside a commit");

   AST_DAC_REG_HOLD: assert property (
      (!frame_ok && !clr_act && !soft_rst_r) |=> $stable(dac_output_code_r))
      else $error("DAC register moved without a write");

   AST_CLEAR_DAC_REG: assert property (
      (!clr_s && !soft_rst_r) |=> dac_output_code_r == $past(clearcode_r))
      else $error("clear pin did not load the DAC register");

   AST_CLEAR_BLOCKS: assert property (
      (clr_act && !soft_rst_r) |=> dac_level == $past(clearcode_r))
      else $error("output left the clearcode during clear");

   AST_DAC_WR_BLOCKED: assert property (
      (wr_en && addr == ADDR_DAC && clr_act && !soft_rst_r) |=> dac_output_code_r == $past(clearcode_r))
      else $error("DAC write beat the clear");

   AST_SW_CLEAR: assert property (
      (sw_clr_r && !soft_rst_r) |=> (dac_output_code_r == $past(clearcode_r) && dac_level == $past(clearcode_r)))
      else $error("software clear missed");

   AST_SW_LOAD: assert property (
      (sw_load_r && sel_s && !clr_act && !soft_rst_r) |=> dac_level == $past(dac_output_code_r))
      else $error("software load missed");

   AST_SW_ONE_CYCLE: assert property (
      (sw_clr_r || sw_load_r || soft_rst_r) |=> !(sw_clr_r || sw_load_r || soft_rst_r))
      else $error("software action longer than one cycle");

   AST_NO_LOAD_IN_FRAME: assert property (
      (!sel_s && !sw_load_r && !clr_act && !soft_rst_r) |=> $stable(dac_level))
      else $error("output updated inside a frame");

   AST_RST_RB: assert property (
      soft_rst_r |=> (rb_word_r == RB_IDLE && dac_output_code_r == CODE_RST))
      else $error("software reset left readback or DAC state");

   AST_OE_DRIVE: assert property (
      (!frame_sel_n && !ctrl_r[CTRL_RBDIS]) |-> serial_readback_line_oe)
      else $error("readback driver off inside an enabled frame");
endmodule
`default_nettype wire

// file: bench/dacsi_host.sv
// Host serial controller model: gated frames out, readback captured on falling edges
`default_nettype none
module dacsi_host (
   // Free-running link clock from the bench
   input  wire logic lk,
   // Serial link
   output logic      sclk,
   output logic      frame_sel_n,
   output logic      serial_input_line,
   input  wire logic rb_line,
   input  wire logic rb_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        en = 1'b0;
   logic [23:0] rb_word = 24'h00_0000;
   logic        oe_any = 1'b0;

   // Gate moves only while lk is low, so the link clock never glitches and stands still between frames
   assign sclk = lk & en;

   // Idle levels before the first frame
   initial begin
      frame_sel_n = 1'b1;
      serial_input_line = 1'b0;
   end

   // One frame of n falling edges, MSB first; data changes just after each falling edge
   task automatic xfer(input logic [23:0] w, input int n);
      @(negedge lk);
      #2;
      frame_sel_n = 1'b0;
      serial_input_line = w[23];
      en = 1'b1;
      oe_any = 1'b0;
      for (int i = 0; i < n; i++) begin
         @(negedge lk);
         if (i < 24) rb_word[23-i] = rb_line;
         oe_any = oe_any | rb_oe;
         #2;
         serial_input_line = (i < 23) ? w[22-i] : ~serial_input_line;
      end
      en = 1'b0;
      #20;
      frame_sel_n = 1'b1;
      serial_input_line = ~serial_input_line;
      // Keeps select high well beyond the minimum gap between frames
      #60;
   endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the DAC serial front end, with queued expectations
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dacsi_pkg::*;
   typedef struct {int kind; logic [23:0] val; string name;} dacsi_note_t;
   logic              sys_clk = 1'b0;
   logic              lk = 1'b0;
   logic              rst_n = 1'b0;
   logic              output_load_n = 1'b0;
   logic              clear_to_code_n = 1'b1;
   wire logic         sclk, frame_sel_n, serial_input_line, rb_o, rb_oe, rb_wire;
   logic [CODE_W-1:0] dac_level;
   logic              coding_select, dac_tristate, output_clamp, amp_bypass;
   dacsi_note_t       notes[$];
   event              result_ev;
   int                bad_count = 0;
   int                cmp_count = 0;

   // System clock, and a link clock with an odd phase offset
   always #4 sys_clk = ~sys_clk;
   initial begin
      #1.3;
      forever #62.5 lk = ~lk;
   end

   // Released readback line reads the inverse of the gated output, so a missing drive cannot pass
   assign rb_wire = rb_oe ? rb_o : ~rb_o;

   dacsi_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .frame_sel_n(frame_sel_n),
      .serial_input_line(serial_input_line), .serial_readback_line_o(rb_o), .serial_readback_line_oe(rb_oe),
      .output_load_n(output_load_n), .clear_to_code_n(clear_to_code_n), .dac_level(dac_level),
      .coding_select(coding_select), .dac_tristate(dac_tristate), .output_clamp(output_clamp),
      .amp_bypass(amp_bypass));
   dacsi_host u_host (.lk(lk), .sclk(sclk), .frame_sel_n(frame_sel_n), .serial_input_line(serial_input_line),
      .rb_line(rb_wire), .rb_oe(rb_oe));

   // Verdict and end of run
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Note an expected result, then wake the monitor
   task automatic expect_val(input int kind, input logic [23:0] val, input string name);
      notes.push_back('{kind, val, name});
      -> result_ev;
   endtask

   // Monitor: drains every pending note against what the outputs show now
   always @(result_ev) begin
      dacsi_note_t n;
      logic [23:0] seen;
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n.kind)
            0: seen = u_host.rb_word;
            1: seen = {6'h00, dac_level};
            2: seen = {20'h0_0000, coding_select, dac_tristate, output_clamp, amp_bypass};
            3: seen = {23'h00_0000, rb_oe};
            default: seen = {23'h00_0000, u_host.oe_any};
         endcase
         cmp_count++;
         if (seen !== n.val) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n.name, n.val, seen);
         end
      end
   end

   function automatic logic [23:0] fw(input logic rw, input logic [2:0] a, input logic [19:0] d);
      return {rw, a, d};
   endfunction

   // Settled sampling point after n system clock edges
   task automatic wait_sys(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // Pin changes always land 1 ns after a rising edge
   task automatic pins(input logic ld, input logic clr, input logic rst);
      wait_sys(1);
      output_load_n = ld;
      clear_to_code_n = clr;
      rst_n = rst;
   endtask

   // A frame plus time for the commit to cross into the system domain
   task automatic frame(input logic [23:0] w, input int n = 24);
      u_host.xfer(w, n);
      wait_sys(6);
   endtask

   // Bounded run length
   initial begin
      repeat (40000) @(posedge sys_clk);
      bad_count++;
      $display("timeout waiting for the sequence");
      summarize();
   end

   // Main sequence
   initial begin
      logic [17:0] code_a, code_b, clr_code;
      void'($urandom(12));
      code_a = 18'($urandom());
      code_b = 18'($urandom());
      clr_code = 18'($urandom());
      repeat (2) @(posedge sys_clk);
      pins(1'b0, 1'b1, 1'b1);
      wait_sys(4);
      expect_val(1, 24'h00_0000, "dac_level_rst");
      expect_val(2, 24'h00_0007, "ctrl_pins_rst");
      frame(fw(1'b1, ADDR_CTRL, 20'h0_0000));
      frame(fw(1'b1, ADDR_CLRC, 20'h0_0000));
      expect_val(0, {1'b1, ADDR_CTRL, CTRL_RST}, "rb_ctrl");
      expect_val(4, 24'h00_0001, "oe_in_frame");
      expect_val(3, 24'h00_0000, "oe_idle");
      frame(fw(1'b0, ADDR_NOP, 20'h0_0000));
      expect_val(0, {1'b1, ADDR_CLRC, 20'h0_0000}, "rb_clrc_rst");
      $display("test reset_and_readback done");
      frame(fw(1'b0, ADDR_DAC, {code_a, 2'($urandom())}));
      expect_val(1, {6'h00, code_a}, "dac_sync");
      frame(fw(1'b1, ADDR_DAC, 20'h0_0000));
      frame(fw(1'b0, ADDR_NOP, 20'h0_0000));
      expect_val(0, {1'b1, ADDR_DAC, code_a, 2'b00}, "rb_dac");
      $display("test sync_write done");
      frame(fw(1'b0, ADDR_DAC, {code_b, 2'b00}), 23);
      expect_val(1, {6'h00, code_a}, "dac_short");
      frame(fw(1'b0, ADDR_DAC, {code_b, 2'b00}), 25);
      expect_val(1, {6'h00, code_a}, "dac_long");
      frame(fw(1'b1, ADDR_NOP, 20'h0_FFFF));
      frame(fw(1'b0, ADDR_NOP, 20'h0_FFFF));
      expect_val(1, {6'h00, code_a}, "dac_nop");
      expect_val(2, 24'h00_0007, "ctrl_nop");
      $display("test invalid_frames done");
      pins(1'b1, 1'b1, 1'b1);
      frame(fw(1'b0, ADDR_DAC, {code_b, 2'b01}));
      expect_val(1, {6'h00, code_a}, "dac_held");
      pins(1'b0, 1'b1, 1'b1);
      wait_sys(4);
      expect_val(1, {6'h00, code_b}, "dac_load_fall");
      pins(1'b1, 1'b1, 1'b1);
      frame(fw(1'b0, ADDR_DAC, {code_a, 2'b00}));
      expect_val(1, {6'h00, code_b}, "dac_held_sw");
      frame(fw(1'b0, ADDR_SWCTL, 20'h0_0001));
      expect_val(1, {6'h00, code_a}, "dac_sw_load");
      $display("test async_load done");
      frame(fw(1'b0, ADDR_CLRC, {clr_code, 2'b00}));
      frame(fw(1'b1, ADDR_CLRC, 20'h0_0000));
      frame(fw(1'b0, ADDR_NOP, 20'h0_0000));
      expect_val(0, {1'b1, ADDR_CLRC, clr_code, 2'b00}, "rb_clrc");
      pins(1'b0, 1'b0, 1'b1);
      wait_sys(4);
      expect_val(1, {6'h00, clr_code}, "dac_clear");
      frame(fw(1'b0, ADDR_DAC, {code_a, 2'b00}));
      expect_val(1, {6'h00, clr_code}, "dac_blocked");
      pins(1'b1, 1'b1, 1'b1);
      wait_sys(4);
      pins(1'b0, 1'b1, 1'b1);
      wait_sys(4);
      expect_val(1, {6'h00, clr_code}, "dac_after_clear");
      frame(fw(1'b0, ADDR_DAC, {code_b, 2'b00}));
      frame(fw(1'b0, ADDR_SWCTL, 20'h0_0002));
      expect_val(1, {6'h00, clr_code}, "dac_sw_clear");
      $display("test clear done");
      frame(fw(1'b0, ADDR_CTRL, 20'h0_0010));
      expect_val(2, 24'h00_0008, "ctrl_coding");
      frame(fw(1'b0, ADDR_CTRL, 20'h0_0020));
      frame(fw(1'b1, ADDR_CTRL, 20'h0_0000));
      frame(fw(1'b0, ADDR_NOP, 20'h0_0000));
      expect_val(4, 24'h00_0000, "oe_disabled");
      frame(fw(1'b0, ADDR_SWCTL, 20'h0_0004));
      expect_val(2, 24'h00_0007, "ctrl_sw_reset");
      expect_val(1, 24'h00_0000, "dac_sw_reset");
      frame(fw(1'b1, ADDR_CLRC, 20'h0_0000));
      frame(fw(1'b0, ADDR_NOP, 20'h0_0000));
      expect_val(0, {1'b1, ADDR_CLRC, 20'h0_0000}, "rb_clrc_sw_reset");
      $display("test control_and_sw_reset done");
      frame(fw(1'b0, ADDR_DAC, {code_a, 2'b00}));
      pins(1'b0, 1'b1, 1'b0);
      frame(fw(1'b0, ADDR_DAC, {code_b, 2'b00}));
      expect_val(1, 24'h00_0000, "dac_in_reset");
      pins(1'b0, 1'b1, 1'b1);
      wait_sys(4);
      expect_val(1, 24'h00_0000, "dac_after_reset");
      $display("test pin_reset done");
      #1;
      summarize();
   end
endmodule
`default_nettype wire
